// file: logic/async_serial_receiver.sv
/*
 Asynchronous serial receiver: start detection, majority bit recovery,
 stop check, two-entry FIFO, overrun, nine-bit and address filtering.
 Assumes a register master with one-cycle strobes and an external line
 that idles high and is not synchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module async_serial_receiver
    import rx_pkg::*;
#(
    parameter int BAUD_RATE = BAUD_DEFAULT,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic rx_pin, // Serial receive line
    output logic rx_irq, // Receive interrupt request
    output logic rx_idle // Sampler waiting for a start edge
);
    localparam int DIVISOR = CLK_HZ / (BAUD_RATE * OVERSAMPLE);

    if (BAUD_RATE < 1 || DIVISOR < 1) begin : g_bad_baud
        $error("async_serial_receiver: baud rate too high for clock");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } rx_state_e;

    // Majority of three oversampled values
    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : maj3

    ctrl_s ctrl_reg, ctrl_next;
    logic overrun_reg, overrun_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
    logic rx_level_reg, rx_level_next;
    logic rx_prev_reg;
    rx_state_e state_reg, state_next;
    logic [3:0] os_cnt_reg, os_cnt_next;
    logic [3:0] bit_idx_reg, bit_idx_next;
    logic [2:0] win_reg, win_next;
    logic [CHAR_W-1:0] rx_shift_register, shift_next;
    logic rx_active;
    logic tick;
    logic bit_val;
    logic frame_done;
    logic frame_frame_error_flag;
    logic addr_reject;
    logic push_valid;
    logic push_ready;
    logic fifo_pop;
    logic pop_valid;
    logic rx_pending_flag;
    rx_entry_s push_data;
    rx_entry_s top;
    logic [3:0] last_idx;

    assign rx_active = ctrl_reg.continuous_rx_enable && !ctrl_reg.sync_mode
        && ctrl_reg.port_enable;

    os_tick_gen #(
        .DIVISOR(DIVISOR)
    ) u_tick (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(rx_active),
        .tick(tick)
    );

    // Line synchroniser; the filtered level moves only when the
    // second and third stages agree, which also rejects one-cycle glitches
    always_comb begin
        rx_level_next = rx_level_reg;
        if (rx_s2_reg == rx_s3_reg) begin
            rx_level_next = rx_s3_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_s3_reg <= 1'b1;
            rx_level_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rx_pin;
            rx_s2_reg <= rx_s1_reg;
            rx_s3_reg <= rx_s2_reg;
            rx_level_reg <= rx_level_next;
        end
    end

    assign last_idx = ctrl_reg.nine_bit_rx_select ? 4'h8 : 4'h7;
    assign bit_val = maj3({win_reg[1:0], rx_level_reg});

    // Bit recovery state machine, stepping on oversample ticks
    always_comb begin
        state_next = state_reg;
        os_cnt_next = os_cnt_reg;
        bit_idx_next = bit_idx_reg;
        win_next = win_reg;
        shift_next = rx_shift_register;
        frame_done = 1'b0;
        frame_frame_error_flag = 1'b0;
        if (tick) begin
            win_next = {win_reg[1:0], rx_level_reg};
        end
        case (state_reg)
            ST_IDLE: begin
                os_cnt_next = 4'h0;
                bit_idx_next = 4'h0;
                if (rx_active && rx_prev_reg && !rx_level_reg) begin
                    state_next = ST_START;
                    shift_next = '0;
                end
            end
            ST_START: begin
                if (tick) begin
                    if (os_cnt_reg == HALF_LAST) begin
                        os_cnt_next = 4'h0;
                        if (bit_val) begin
                            state_next = ST_IDLE;
                        end else begin
                            state_next = ST_DATA;
                        end
                    end else begin
                        os_cnt_next = os_cnt_reg + 4'h1;
                    end
                end
            end
            ST_DATA: begin
                if (tick) begin
                    os_cnt_next = os_cnt_reg + 4'h1;
                    if (os_cnt_reg == FULL_LAST) begin
                        shift_next[bit_idx_reg] = bit_val;
                        bit_idx_next = bit_idx_reg + 4'h1;
                        if (bit_idx_reg == last_idx) begin
                            state_next = ST_STOP;
                        end
                    end
                end
            end
            ST_STOP: begin
                if (tick) begin
                    os_cnt_next = os_cnt_reg + 4'h1;
                    if (os_cnt_reg == FULL_LAST) begin
                        frame_done = 1'b1;
                        frame_frame_error_flag = !bit_val;
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (!rx_active) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            os_cnt_reg <= 4'h0;
            bit_idx_reg <= 4'h0;
            win_reg <= 3'h7;
            rx_shift_register <= '0;
            rx_prev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            os_cnt_reg <= os_cnt_next;
            bit_idx_reg <= bit_idx_next;
            win_reg <= win_next;
            rx_shift_register <= shift_next;
            rx_prev_reg <= rx_level_reg;
        end
    end

    // Address filter drops nine-bit characters whose ninth bit is clear
    assign addr_reject = ctrl_reg.addr_detect_enable
        && ctrl_reg.nine_bit_rx_select && !shift_next[8];
    // Overrun blocks the push; FIFO contents stay readable
    assign push_valid = frame_done && !addr_reject
        && !overrun_reg;
    assign push_data.frame_error_flag = frame_frame_error_flag;
    assign push_data.data = ctrl_reg.nine_bit_rx_select ? shift_next
        : {1'b0, shift_next[7:0]};
    assign fifo_pop = reg_rd && (reg_addr == OFF_RX_DATA);

    rx_fifo #(
        .DEPTH(DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .flush(!ctrl_reg.port_enable),
        .push_valid(push_valid),
        .push_ready(push_ready),
        .push_data(push_data),
        .pop(fifo_pop),
        .pop_valid(pop_valid),
        .top(top)
    );

    // Pending follows occupancy while reception is active; no software path writes it
    assign rx_pending_flag = rx_active && pop_valid;
    // Framing error has no path to the request
    assign rx_irq = rx_pending_flag && ctrl_reg.rx_irq_enable
        && ctrl_reg.peripheral_irq_gate
        && ctrl_reg.global_irq_gate;
    assign rx_idle = (state_reg == ST_IDLE);

    // Overrun: set by a complete character that passes the address filter and finds the FIFO full;
    // cleared while either enable is low, when no frame can finish
    always_comb begin
        overrun_next = overrun_reg;
        if (!ctrl_reg.continuous_rx_enable || !ctrl_reg.port_enable) begin
            overrun_next = 1'b0;
        end
        if (frame_done && !addr_reject && !overrun_reg && !push_ready) begin
            overrun_next = 1'b1;
        end
    end

    // Control writes; status bits and the pending flag ignore writes
    always_comb begin
        ctrl_next = ctrl_reg;
        if (reg_wr) begin
            case (reg_addr)
                OFF_RX_STATUS_CTRL: begin
                    ctrl_next.port_enable = reg_wdata[BIT_PORT_EN];
                    ctrl_next.nine_bit_rx_select = reg_wdata[BIT_NINE];
                    ctrl_next.continuous_rx_enable = reg_wdata[BIT_CONT_RX];
                    ctrl_next.addr_detect_enable = reg_wdata[BIT_ADDR_DET];
                end
                OFF_MODE: begin
                    ctrl_next.sync_mode = reg_wdata[BIT_SYNC];
                end
                OFF_PERIPH_EN: begin
                    ctrl_next.rx_irq_enable = reg_wdata[BIT_IRQ_EN];
                end
                OFF_IRQ_CTRL: begin
                    ctrl_next.global_irq_gate = reg_wdata[BIT_GLB_GATE];
                    ctrl_next.peripheral_irq_gate = reg_wdata[BIT_PER_GATE];
                end
                default: begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
    end

    // Read mux; status shows the top entry before a data read pops it.
    // An empty or flushed FIFO shows no framing error or ninth bit.
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFF_RX_STATUS_CTRL: begin
                    rdata_next[BIT_PORT_EN] = ctrl_reg.port_enable;
                    rdata_next[BIT_NINE] = ctrl_reg.nine_bit_rx_select;
                    rdata_next[BIT_CONT_RX] = ctrl_reg.continuous_rx_enable;
                    rdata_next[BIT_ADDR_DET] = ctrl_reg.addr_detect_enable;
                    rdata_next[BIT_FRAME] = pop_valid && top.frame_error_flag;
                    rdata_next[BIT_OVERRUN] = overrun_reg;
                    rdata_next[BIT_9TH] = pop_valid && top.data[8];
                end
                OFF_RX_DATA: begin
                    rdata_next = pop_valid ? top.data[7:0] : 8'h00;
                end
                OFF_MODE: begin
                    rdata_next[BIT_IDLE] = rx_idle;
                    rdata_next[BIT_SYNC] = ctrl_reg.sync_mode;
                end
                OFF_PERIPH_EN: begin
                    rdata_next[BIT_IRQ_EN] = ctrl_reg.rx_irq_enable;
                end
                OFF_IRQ_CTRL: begin
                    rdata_next[BIT_GLB_GATE] = ctrl_reg.global_irq_gate;
                    rdata_next[BIT_PER_GATE] = ctrl_reg.peripheral_irq_gate;
                end
                OFF_PERIPH_FLAG: begin
                    rdata_next[BIT_PENDING] = rx_pending_flag;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_reg <= ctrl_s'(REG_RESET);
            overrun_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            overrun_reg <= overrun_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule : async_serial_receiver
`default_nettype wire

// file: logic/rx_pkg.sv
/*
 Constants, field layouts and carrier types for the asynchronous receiver.
 Assumes a single 100 MHz clock and an 8-bit register port.
*/
package rx_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CHAR_W = 9;
    // Register offsets
    localparam logic [2:0] OFF_RX_STATUS_CTRL = 3'h0;
    localparam logic [2:0] OFF_RX_DATA = 3'h1;
    localparam logic [2:0] OFF_MODE = 3'h2;
    localparam logic [2:0] OFF_PERIPH_EN = 3'h3;
    localparam logic [2:0] OFF_IRQ_CTRL = 3'h4;
    localparam logic [2:0] OFF_PERIPH_FLAG = 3'h5;
    // Field positions
    localparam int BIT_PORT_EN = 7;
    localparam int BIT_NINE = 6;
    localparam int BIT_CONT_RX = 4;
    localparam int BIT_ADDR_DET = 3;
    localparam int BIT_FRAME = 2;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_9TH = 0;
    localparam int BIT_IDLE = 6;
    localparam int BIT_SYNC = 4;
    localparam int BIT_IRQ_EN = 5;
    localparam int BIT_GLB_GATE = 7;
    localparam int BIT_PER_GATE = 6;
    localparam int BIT_PENDING = 5;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_DEFAULT = 115_200;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] HALF_LAST = 4'h7;
    localparam logic [3:0] FULL_LAST = 4'hf;
    localparam int FIFO_DEPTH = 2;

    typedef struct packed {
        logic frame_error_flag;
        logic [CHAR_W-1:0] data;
    } rx_entry_s;

    typedef struct packed {
        logic port_enable;
        logic nine_bit_rx_select;
        logic continuous_rx_enable;
        logic addr_detect_enable;
        logic sync_mode;
        logic rx_irq_enable;
        logic global_irq_gate;
        logic peripheral_irq_gate;
    } ctrl_s;
endpackage : rx_pkg

// file: logic/os_tick_gen.sv
/*
 Oversample tick divider: one-cycle enable pulse at sixteen times the baud.
 Assumes the same clock and reset as the receiver that uses it.
*/
`timescale 1ns/100ps
`default_nettype none
module os_tick_gen #(
    parameter int DIVISOR = 54
) (
    input wire logic sys_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic run, // Divider runs while high
    output logic tick // One-cycle oversample pulse
);
    // The counter is sixteen bits wide, so larger divisors cannot be served
    if (DIVISOR < 1 || DIVISOR > 65536) begin : g_bad_div
        $error("os_tick_gen: DIVISOR must be 1 to 65536");
    end

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    localparam logic [15:0] LAST = 16'(DIVISOR - 1);

    // Restart from zero whenever stopped so ticks align with enable
    always_comb begin
        cnt_next = cnt_reg;
        if (!run || cnt_reg == LAST) begin
            cnt_next = 16'h0000;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick = run && (cnt_reg == LAST);
endmodule : os_tick_gen
`default_nettype wire

// file: logic/rx_fifo.sv
/*
 Receive FIFO holding characters with their framing status.
 Assumes pushes and pops come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_fifo
    import rx_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic flush, // Empties the FIFO
    input wire logic push_valid, // Character offered
    output logic push_ready, // Room for a character
    input wire rx_entry_s push_data, // Character and status
    input wire logic pop, // Remove oldest entry
    output logic pop_valid, // At least one entry
    output rx_entry_s top // Oldest entry
);
    if (DEPTH < 2 || DEPTH > 16) begin : g_bad_depth
        $error("rx_fifo: DEPTH must be 2 to 16");
    end

    localparam int PW = $clog2(DEPTH);
    localparam logic [4:0] DEPTH_C = 5'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    rx_entry_s mem [DEPTH];
    logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [4:0] cnt_reg, cnt_next;
    logic do_push, do_pop;

    assign push_ready = (cnt_reg != DEPTH_C);
    assign pop_valid = (cnt_reg != 5'h00);
    assign do_push = push_valid && push_ready;
    assign do_pop = pop && pop_valid;
    assign top = mem[rd_reg];

    // Pointer and occupancy update; flush overrides traffic
    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (flush) begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = 5'h00;
        end else begin
            if (do_push) begin
                wr_next = (wr_reg == PTR_LAST) ? '0 : wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_next = (rd_reg == PTR_LAST) ? '0 : rd_reg + 1'b1;
            end
            cnt_next = cnt_reg + {4'h0, do_push} - {4'h0, do_pop};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= 5'h00;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; only entries below the count are visible
    always_ff @(posedge sys_clk) begin
        if (do_push && !flush) begin
            mem[wr_reg] <= push_data;
        end
    end
endmodule : rx_fifo
`default_nettype wire

// file: verif/serial_tx_model.sv
/*
 Remote serial transmitter driving the receive line, 8N1 or 9N1.
 Assumes the bench calls its tasks; bit time counts sys_clk cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_tx_model #(
    parameter int BIT_CYC = 16
) (
    input wire logic sys_clk, // Clock the bit timing counts on
    output logic line // Serial line toward the receiver
);
    // Line idles high between frames, as a pulled-up line would
    initial begin
        line = 1'b1;
    end

    // Hold one level for a number of cycles, changed just after an edge
    task automatic hold(input logic lvl, input int cyc);
        @(posedge sys_clk);
        line <= lvl;
        repeat (cyc - 1) @(posedge sys_clk);
    endtask : hold

    // One frame, LSB first; a low stop level forces a framing fault
    task automatic send(input logic [8:0] data, input int nbits,
                        input logic stop);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < nbits; i++) begin
            hold(data[i], BIT_CYC);
        end
        hold(stop, BIT_CYC);
        hold(1'b1, 2 * BIT_CYC);
    endtask : send

    // Short low pulse that must not survive the start centre check
    task automatic glitch();
        hold(1'b0, BIT_CYC / 4);
        hold(1'b1, 2 * BIT_CYC);
    endtask : glitch
endmodule : serial_tx_model
`default_nettype wire

// file: verif/async_serial_receiver_properties.sv
/*
 Port-level checker for the asynchronous receiver, bound to its top.
 Assumes control bits change only through register writes.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_checker
    import rx_pkg::*;
#(
    parameter int BAUD_RATE = BAUD_DEFAULT,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk, // Clock
    input wire logic srst, // Synchronous reset
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // Read data
    input wire logic rx_pin, // Serial line
    input wire logic rx_irq, // Interrupt request
    input wire logic rx_idle // Sampler idle
);
    localparam int DIV = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
    localparam int FRAME_MAX = DIV * OVERSAMPLE * 12 + 8;
    logic port_en_reg, rx_on_reg, sync_reg, irq_en_reg, glb_reg, per_reg;
    int busy_reg;
    int low_age_reg;
    logic gates_all;

    // Shadow of the control bits, followed from the write strobes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {port_en_reg, rx_on_reg, sync_reg} <= 3'h0;
            {irq_en_reg, glb_reg, per_reg} <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_RX_STATUS_CTRL: begin
                    port_en_reg <= reg_wdata[BIT_PORT_EN];
                    rx_on_reg <= reg_wdata[BIT_CONT_RX];
                end
                OFF_MODE: sync_reg <= reg_wdata[BIT_SYNC];
                OFF_PERIPH_EN: irq_en_reg <= reg_wdata[BIT_IRQ_EN];
                OFF_IRQ_CTRL: begin
                    glb_reg <= reg_wdata[BIT_GLB_GATE];
                    per_reg <= reg_wdata[BIT_PER_GATE];
                end
                default: ;
            endcase
        end
    end

    // Busy length, and time since the line was last low saturating at 15
    always_ff @(posedge sys_clk) begin
        busy_reg <= (srst || rx_idle) ? 0 : busy_reg + 1;
        low_age_reg <= (srst || rx_pin) ? ((low_age_reg < 15 && !srst) ?
                       low_age_reg + 1 : 15) : 0;
    end

    // Every gate of the request, reception itself included
    assign gates_all = port_en_reg && rx_on_reg && !sync_reg && irq_en_reg &&
                       glb_reg && per_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence start_seen;
        $fell(rx_idle);
    endsequence
    sequence data_read;
        reg_rd && reg_addr == OFF_RX_DATA;
    endsequence

    rdata_quiet_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    irq_gated_a: assert property (rx_irq |-> gates_all)
        else $error("interrupt with a gate closed");
    empty_read_zero_a: assert property (
        gates_all && !rx_irq ##0 data_read |=> reg_rdata == 8'h00)
        else $error("data from an empty queue");
    start_needs_low_a: assert property (
        start_seen |-> low_age_reg <= 6)
        else $error("start without a low line");
    start_active_a: assert property (
        start_seen |-> port_en_reg && rx_on_reg && !sync_reg)
        else $error("start while reception is off");
    half_bit_a: assert property (start_seen |=> !rx_idle [*6])
        else $error("start dropped before its centre");
    frame_bounded_a: assert property (busy_reg < FRAME_MAX)
        else $error("frame longer than its bit count");
    idle_on_disable_a: assert property (
        reg_wr && reg_addr == OFF_RX_STATUS_CTRL && !reg_wdata[BIT_PORT_EN]
        |-> ##[1:3] rx_idle)
        else $error("sampler not idle after port disable");
endmodule : rx_checker

bind async_serial_receiver rx_checker #(.BAUD_RATE(BAUD_RATE), .DEPTH(DEPTH))
    u_rx_checker (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .rx_irq(rx_irq),
    .rx_idle(rx_idle));
`default_nettype wire

// file: verif/testbench.sv
/*
 Self-checking bench for the asynchronous receiver and its registers.
 Assumes a fast baud so one bit is sixteen clock cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
    import rx_pkg::*;
;
    localparam int BIT_CYC = 16;
    localparam logic [7:0] ST_ON = 8'h90;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 3'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    wire logic rx_pin;
    logic rx_irq, rx_idle;
    int miscompares = 0;
    int compares = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    async_serial_receiver #(.BAUD_RATE(6_250_000)) u_async_serial_receiver (
        .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_pin(rx_pin), .rx_irq(rx_irq),
        .rx_idle(rx_idle));
    serial_tx_model #(.BIT_CYC(BIT_CYC)) u_serial_tx_model (
        .sys_clk(sys_clk), .line(rx_pin));

    task automatic check(input string what, input logic [8:0] exp,
                         input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // One-cycle write strobe, released on the next edge
    task automatic reg_write(input logic [2:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [2:0] addr, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", {1'b0, exp}, {1'b0, reg_rdata});
    endtask : reg_check

    task automatic irq_check(input logic exp);
        @(posedge sys_clk);
        #1;
        check("rx_irq", {8'h00, exp}, {8'h00, rx_irq});
    endtask : irq_check

    task automatic complete_run();
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Watchdog sized well above the roughly 2900 cycles of traffic
    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end

    // Main sequence; software reads status before each data read except the empty-queue read after 8'h3c
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            reg_check(a[2:0], (a == 2) ? 8'h40 : 8'h00);
        end
        reg_write(OFF_PERIPH_FLAG, 8'hff);
        reg_check(OFF_PERIPH_FLAG, 8'h00);
        reg_write(OFF_RX_STATUS_CTRL, 8'h80);
        reg_write(OFF_PERIPH_EN, 8'h20);
        reg_write(OFF_IRQ_CTRL, 8'hc0);
        reg_write(OFF_RX_STATUS_CTRL, ST_ON);
        u_serial_tx_model.send(9'h0a5, 8, 1'b1);
        u_serial_tx_model.send(9'h03c, 8, 1'b0);
        irq_check(1'b1);
        reg_check(OFF_PERIPH_FLAG, 8'h20);
        reg_check(OFF_RX_STATUS_CTRL, 8'h90);
        reg_check(OFF_RX_DATA, 8'ha5);
        reg_check(OFF_RX_STATUS_CTRL, 8'h94);
        reg_check(OFF_RX_DATA, 8'h3c);
        irq_check(1'b0);
        reg_check(OFF_RX_DATA, 8'h00);
        u_serial_tx_model.glitch();
        reg_check(OFF_MODE, 8'h40);
        irq_check(1'b0);
        reg_write(OFF_MODE, 8'h10);
        u_serial_tx_model.send(9'h077, 8, 1'b1);
        irq_check(1'b0);
        reg_write(OFF_MODE, 8'h00);
        // Three characters into a two-deep queue
        u_serial_tx_model.send(9'h011, 8, 1'b1);
        u_serial_tx_model.send(9'h022, 8, 1'b1);
        u_serial_tx_model.send(9'h033, 8, 1'b1);
        reg_check(OFF_RX_STATUS_CTRL, 8'h92);
        for (int g = 0; g < 3; g++) begin
            reg_write(OFF_IRQ_CTRL, g == 0 ? 8'h80 : (g == 1 ? 8'h40 : 8'hc0));
            reg_write(OFF_PERIPH_EN, g == 2 ? 8'h00 : 8'h20);
            irq_check(1'b0);
            reg_check(OFF_PERIPH_FLAG, 8'h20);
        end
        reg_write(OFF_PERIPH_EN, 8'h20);
        irq_check(1'b1);
        reg_check(OFF_RX_DATA, 8'h11);
        reg_check(OFF_RX_STATUS_CTRL, 8'h92);
        reg_check(OFF_RX_DATA, 8'h22);
        u_serial_tx_model.send(9'h044, 8, 1'b1);
        irq_check(1'b0);
        reg_write(OFF_RX_STATUS_CTRL, 8'h80);
        reg_check(OFF_RX_STATUS_CTRL, 8'h80);
        reg_write(OFF_RX_STATUS_CTRL, ST_ON);
        u_serial_tx_model.send(9'h055, 8, 1'b1);
        reg_check(OFF_RX_STATUS_CTRL, 8'h90);
        reg_check(OFF_RX_DATA, 8'h55);
        // Nine-bit frames, then address filtering
        reg_write(OFF_RX_STATUS_CTRL, 8'hd0);
        u_serial_tx_model.send(9'h1a5, 9, 1'b1);
        reg_check(OFF_RX_STATUS_CTRL, 8'hd1);
        reg_check(OFF_RX_DATA, 8'ha5);
        reg_write(OFF_RX_STATUS_CTRL, 8'hc8);
        reg_write(OFF_RX_STATUS_CTRL, 8'hd8);
        u_serial_tx_model.send(9'h0f0, 9, 1'b1);
        irq_check(1'b0);
        u_serial_tx_model.send(9'h1c3, 9, 1'b1);
        reg_check(OFF_RX_STATUS_CTRL, 8'hd9);
        reg_write(OFF_RX_STATUS_CTRL, 8'hd0);
        u_serial_tx_model.send(9'h066, 9, 1'b1);
        reg_check(OFF_RX_DATA, 8'hc3);
        reg_check(OFF_RX_STATUS_CTRL, 8'hd0);
        reg_check(OFF_RX_DATA, 8'h66);
        // Framing status survives a receive disable, not a port disable
        reg_write(OFF_RX_STATUS_CTRL, ST_ON);
        u_serial_tx_model.send(9'h0e1, 8, 1'b0);
        reg_write(OFF_RX_STATUS_CTRL, 8'h80);
        reg_check(OFF_RX_STATUS_CTRL, 8'h84);
        reg_write(OFF_RX_STATUS_CTRL, ST_ON);
        fork
            u_serial_tx_model.send(9'h0ff, 8, 1'b1);
            begin
                repeat (40) @(posedge sys_clk);
                reg_write(OFF_RX_STATUS_CTRL, 8'h00);
            end
        join
        reg_check(OFF_RX_STATUS_CTRL, 8'h00);
        reg_check(OFF_RX_DATA, 8'h00);
        reg_check(OFF_MODE, 8'h40);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
